// ### alcce_regs.vh
// Purpose: constants for the add/logic/call/carry execution block
// Assumes: 8-bit data, 8-bit register-file address, 16-bit program counter
// Notes: flag bit positions are a local choice; opcodes are as decoded by the core
`ifndef ALCCE_REGS_VH
`define ALCCE_REGS_VH
`define ALCCE_FLAGS_ADDR 8'hd5
`define ALCCE_FLAGS_RESET 8'h00
`define ALCCE_FLAG_C 7
`define ALCCE_FLAG_Z 6
`define ALCCE_FLAG_S 5
`define ALCCE_FLAG_V 4
`define ALCCE_STKP_ADDR 8'hd9
`define ALCCE_STKP_RESET 8'h00
`define ALCCE_OP_ADD 4'h0
`define ALCCE_OP_ADC 4'h1
`define ALCCE_OP_AND 4'h5
`define ALCCE_OPC_CALL_DIR 8'hf6
`define ALCCE_OPC_CALL_IRR 8'hf4
`define ALCCE_OPC_RETURN 8'haf
`define ALCCE_OPC_CTOG 8'hef
`define ALCCE_CYC_RR 4'h4
`define ALCCE_CYC_6 4'h6
`define ALCCE_CYC_CALL_IRR 4'hc
`define ALCCE_CYC_CALL_DIR 4'he
`define ALCCE_CYC_RETURN 4'h8
`endif

// ### alcce_alu.v
// Purpose: 8-bit add, add-with-carry and and, with flag results
// Assumes: sel 0 add, 1 adc, 2 and
// Notes: purely combinational
`timescale 1ns/10ps
module alcce_alu (
	input wire [1:0] sel,
	input wire [7:0] dst,
	input wire [7:0] src,
	input wire carry_in,
	input wire [3:0] flags_in,
	output reg [7:0] result,
	output reg [3:0] flags_out
);
	reg [8:0] sum;
	// flags_out packs c,z,s,v from high to low
	always @* begin
		sum = {1'b0, dst} + {1'b0, src} + {8'h00, (sel == 2'd1) & carry_in};
		result = sum[7:0];
		flags_out = flags_in;
		if (sel == 2'd2) begin
			result = dst & src;
			flags_out = {flags_in[3], (result == 8'h00), result[7], 1'b0};
		end else begin
			flags_out = {sum[8], (result == 8'h00), result[7],
				(dst[7] == src[7]) & (result[7] != dst[7])};
		end
	end
endmodule // alcce_alu

// ### alcce_decode.v
// Purpose: opcode decode into operation, source mode, byte length and cycles
// Assumes: opcode byte valid while decode is used
// Notes: unknown opcodes flag illegal and write nothing, but still run four cycles and step pc by one
`timescale 1ns/10ps
`include "alcce_regs.vh"
module alcce_decode (
	input wire [7:0] opcode,
	output reg legal,
	output reg [1:0] alu_sel,
	output reg [2:0] mode,
	output reg [1:0] length,
	output reg [3:0] cycles,
	output reg is_call,
	output reg is_return,
	output reg is_ctog
);
	// mode: 0 rr, 1 r-indirect, 2 RR, 3 R-indirect, 4 imm
	always @* begin
		legal = 1'b0;
		alu_sel = 2'd0;
		mode = 3'd0;
		length = 2'd1;
		cycles = `ALCCE_CYC_RR;
		is_call = 1'b0;
		is_return = 1'b0;
		is_ctog = 1'b0;
		if ((opcode[7:4] == `ALCCE_OP_ADD || opcode[7:4] == `ALCCE_OP_ADC || opcode[7:4] == `ALCCE_OP_AND)
			&& opcode[3:0] >= 4'h2 && opcode[3:0] <= 4'h6) begin
			legal = 1'b1;
			alu_sel = (opcode[7:4] == `ALCCE_OP_ADD) ? 2'd0 : (opcode[7:4] == `ALCCE_OP_ADC) ? 2'd1 : 2'd2;
			mode = opcode[2:0] - 3'd2;
			length = (opcode[3:0] < 4'h4) ? 2'd2 : 2'd3;
			cycles = (opcode[3:0] == 4'h2) ? `ALCCE_CYC_RR : `ALCCE_CYC_6;
		end else begin
			case (opcode)
				`ALCCE_OPC_CALL_DIR: begin
					legal = 1'b1;
					is_call = 1'b1;
					length = 2'd3;
					cycles = `ALCCE_CYC_CALL_DIR;
				end
				`ALCCE_OPC_CALL_IRR: begin
					legal = 1'b1;
					is_call = 1'b1;
					length = 2'd2;
					cycles = `ALCCE_CYC_CALL_IRR;
				end
				`ALCCE_OPC_RETURN: begin
					legal = 1'b1;
					is_return = 1'b1;
					cycles = `ALCCE_CYC_RETURN;
				end
				`ALCCE_OPC_CTOG: begin
					legal = 1'b1;
					is_ctog = 1'b1;
				end
				default: begin
					legal = 1'b0;
				end
			endcase
		end
	end
endmodule // alcce_decode

// ### alcce_exec.v
// Purpose: executes add, adc, and, call, return and complement-carry
// Assumes: register file and stack answer reads combinationally in the same cycle
// Notes: operands and instruction bytes are given with START; DONE pulses at end
// Function
// - adc adds source and carry into destination
// - add sums destination and source, no carry
// - source location never written by alu ops
// - carry set on carry out of bit 7
// - zero and sign follow the 8-bit result
// - overflow on same-sign operands, opposite result
// - and is bitwise and into destination
// - and keeps carry, clears overflow, sets z,s
// - return address is next instruction address
// - push low byte then high byte, predecrementing
// - after push, program counter takes target
// - call leaves all flags alone
// - return pops address into program counter
// - complement-carry inverts only carry
// - flags register lives at address d5
`timescale 1ns/10ps
`include "alcce_regs.vh"
module alcce_exec (
	input wire MCLK,
	input wire RST_N,
	input wire START,
	input wire [7:0] OPCODE,
	input wire [7:0] BYTE1,
	input wire [7:0] BYTE2,
	input wire [15:0] PC_IN,
	output reg [15:0] PC_OUT,
	output reg PC_LOAD,
	output reg BUSY,
	output reg DONE,
	output reg ILLEGAL,
	output reg [3:0] CYCLES,
	output reg [7:0] RF_ADDR,
	input wire [7:0] RF_RDATA,
	output reg [7:0] RF_WADDR,
	output reg [7:0] RF_WDATA,
	output reg RF_WE,
	input wire [7:0] REG_ADDR,
	input wire [7:0] REG_WDATA,
	input wire REG_WR,
	input wire REG_RD,
	output reg [7:0] REG_RDATA
);
	localparam S_IDLE = 3'd0;
	localparam S_IND = 3'd1;
	localparam S_SRC = 3'd2;
	localparam S_DST = 3'd3;
	localparam S_PUSH = 3'd4;
	localparam S_POP = 3'd5;
	localparam S_WAIT = 3'd6;

	reg [2:0] state_reg, state_next;
	reg [7:0] flags_reg, flags_next;
	reg [7:0] stkp_reg, stkp_next;
	reg [7:0] op_reg, op_next;
	reg [7:0] b1_reg, b1_next;
	reg [7:0] b2_reg, b2_next;
	reg [7:0] src_reg, src_next;
	reg [7:0] daddr_reg, daddr_next;
	reg [15:0] radr_reg, radr_next;
	reg [15:0] tgt_reg, tgt_next;
	reg [1:0] step_reg, step_next;
	reg [3:0] cnt_reg, cnt_next;
	wire legal;
	wire [1:0] alu_sel;
	wire [2:0] mode;
	wire [1:0] length;
	wire [3:0] cycles;
	wire is_call, is_return, is_ctog;
	wire [7:0] alu_res;
	wire [3:0] alu_flags;
	wire [1:0] dmode_sel;
	wire [2:0] run_mode;
	wire [1:0] run_sel;

	alcce_decode u_dec (
		.opcode((START && state_reg == S_IDLE) ? OPCODE : op_reg), // a refused start must not disturb the running op
		.legal(legal),
		.alu_sel(alu_sel),
		.mode(mode),
		.length(length),
		.cycles(cycles),
		.is_call(is_call),
		.is_return(is_return),
		.is_ctog(is_ctog)
	);

	// destination is read directly in S_DST, src_reg holds the fetched source
	alcce_alu u_alu (
		.sel(alu_sel),
		.dst(RF_RDATA),
		.src(src_reg),
		.carry_in(flags_reg[`ALCCE_FLAG_C]),
		.flags_in({flags_reg[`ALCCE_FLAG_C], flags_reg[`ALCCE_FLAG_Z], flags_reg[`ALCCE_FLAG_S],
			flags_reg[`ALCCE_FLAG_V]}),
		.result(alu_res),
		.flags_out(alu_flags)
	);
	assign dmode_sel = alu_sel;
	assign run_mode = mode;
	assign run_sel = dmode_sel;

	// working-register form 0x (short 2-byte) carries dst in high nibble, src in low
	function [7:0] short_dst;
		input [7:0] b;
		short_dst = {4'h0, b[7:4]};
	endfunction
	function [7:0] short_src;
		input [7:0] b;
		short_src = {4'h0, b[3:0]};
	endfunction

	// sequencer: all memory and flag effects are computed here
	always @* begin
		state_next = state_reg;
		flags_next = flags_reg;
		stkp_next = stkp_reg;
		op_next = op_reg;
		b1_next = b1_reg;
		b2_next = b2_reg;
		src_next = src_reg;
		daddr_next = daddr_reg;
		radr_next = radr_reg;
		tgt_next = tgt_reg;
		step_next = step_reg;
		cnt_next = cnt_reg;
		RF_ADDR = 8'h00;
		RF_WADDR = 8'h00;
		RF_WDATA = 8'h00;
		RF_WE = 1'b0;
		case (state_reg)
			S_IDLE: begin
				if (START) begin
					op_next = OPCODE;
					b1_next = BYTE1;
					b2_next = BYTE2;
					cnt_next = cycles - 4'h1;
					radr_next = PC_IN + {14'h0000, length};
					tgt_next = {BYTE1, BYTE2};
					step_next = 2'd0;
					if (!legal) begin
						state_next = S_WAIT;
					end else if (is_ctog) begin
						flags_next[`ALCCE_FLAG_C] = ~flags_reg[`ALCCE_FLAG_C];
						state_next = S_WAIT;
					end else if (is_call) begin
						state_next = (OPCODE == `ALCCE_OPC_CALL_IRR) ? S_IND : S_PUSH;
					end else if (is_return) begin
						state_next = S_POP;
					end else begin
						state_next = (mode == 3'd1 || mode == 3'd3) ? S_IND : S_SRC;
					end
				end
			end
			S_IND: begin
				if (is_call) begin
					// pair target: even register high byte, next odd register low byte
					RF_ADDR = {b1_reg[7:1], step_reg[0]};
					if (step_reg == 2'd0) begin
						tgt_next[15:8] = RF_RDATA;
						step_next = 2'd1;
					end else begin
						tgt_next[7:0] = RF_RDATA;
						step_next = 2'd0;
						state_next = S_PUSH;
					end
				end else begin
					// fetch pointer from the named register, then the operand it points at
					RF_ADDR = (run_mode == 3'd1) ? short_src(b1_reg) : b1_reg;
					src_next = RF_RDATA;
					state_next = S_SRC;
				end
			end
			S_SRC: begin
				case (run_mode)
					3'd0: RF_ADDR = short_src(b1_reg);
					3'd1: RF_ADDR = src_reg;
					3'd2: RF_ADDR = b1_reg;
					3'd3: RF_ADDR = src_reg;
					default: RF_ADDR = 8'h00;
				endcase
				src_next = (run_mode == 3'd4) ? b2_reg : RF_RDATA;
				daddr_next = (run_mode < 3'd2) ? short_dst(b1_reg) : ((run_mode == 3'd4) ? b1_reg : b2_reg);
				state_next = S_DST;
			end
			S_DST: begin
				RF_ADDR = daddr_reg;
				RF_WADDR = daddr_reg;
				RF_WDATA = alu_res;
				RF_WE = 1'b1;
				flags_next[`ALCCE_FLAG_C] = alu_flags[3];
				flags_next[`ALCCE_FLAG_Z] = alu_flags[2];
				flags_next[`ALCCE_FLAG_S] = alu_flags[1];
				flags_next[`ALCCE_FLAG_V] = alu_flags[0];
				if (run_sel == 2'd3) begin
					flags_next = flags_reg;
				end
				state_next = S_WAIT;
			end
			S_PUSH: begin
				// flags untouched throughout the push
				RF_WADDR = stkp_reg - 8'h01;
				RF_WDATA = (step_reg == 2'd0) ? radr_reg[7:0] : radr_reg[15:8];
				RF_WE = 1'b1;
				stkp_next = stkp_reg - 8'h01;
				if (step_reg == 2'd0) begin
					step_next = 2'd1;
				end else begin
					state_next = S_WAIT;
				end
			end
			S_POP: begin
				// high byte sits on top, low byte below it
				RF_ADDR = stkp_reg;
				if (step_reg == 2'd0) begin
					tgt_next[15:8] = RF_RDATA;
					step_next = 2'd1;
				end else begin
					tgt_next[7:0] = RF_RDATA;
					state_next = S_WAIT;
				end
				stkp_next = stkp_reg + 8'h01;
			end
			S_WAIT: begin
				if (cnt_reg <= 4'h1) begin
					state_next = S_IDLE;
				end
			end
			default: state_next = S_IDLE;
		endcase
		if (state_reg != S_IDLE && cnt_reg != 4'h0) begin
			cnt_next = cnt_reg - 4'h1;
		end
		// software write to flags or stack pointer; hardware update in same cycle wins
		if (REG_WR && REG_ADDR == `ALCCE_FLAGS_ADDR && !(state_reg == S_DST || (START && is_ctog && state_reg == S_IDLE))) begin
			flags_next = REG_WDATA;
		end
		if (REG_WR && REG_ADDR == `ALCCE_STKP_ADDR && state_reg != S_PUSH && state_reg != S_POP) begin
			stkp_next = REG_WDATA;
		end
	end

	// state and outputs; a finished instruction pulses DONE for one cycle
	always @(posedge MCLK or negedge RST_N) begin
		if (!RST_N) begin
			state_reg <= S_IDLE;
			flags_reg <= `ALCCE_FLAGS_RESET;
			stkp_reg <= `ALCCE_STKP_RESET;
			op_reg <= 8'h00;
			b1_reg <= 8'h00;
			b2_reg <= 8'h00;
			src_reg <= 8'h00;
			daddr_reg <= 8'h00;
			radr_reg <= 16'h0000;
			tgt_reg <= 16'h0000;
			step_reg <= 2'd0;
			cnt_reg <= 4'h0;
			PC_OUT <= 16'h0000;
			PC_LOAD <= 1'b0;
			DONE <= 1'b0;
			ILLEGAL <= 1'b0;
			CYCLES <= 4'h0;
			REG_RDATA <= 8'h00;
		end else begin
			state_reg <= state_next;
			flags_reg <= flags_next;
			stkp_reg <= stkp_next;
			op_reg <= op_next;
			b1_reg <= b1_next;
			b2_reg <= b2_next;
			src_reg <= src_next;
			daddr_reg <= daddr_next;
			radr_reg <= radr_next;
			tgt_reg <= tgt_next;
			step_reg <= step_next;
			cnt_reg <= cnt_next;
			DONE <= (state_reg == S_WAIT) && (state_next == S_IDLE);
			PC_LOAD <= (state_reg == S_WAIT) && (state_next == S_IDLE) && (is_call || is_return);
			// new pc only moves at the end, so it stands until the next instruction ends
			if (state_reg == S_WAIT && state_next == S_IDLE) begin
				PC_OUT <= (is_call || is_return) ? tgt_reg : radr_reg;
			end
			if (START && state_reg == S_IDLE) begin
				ILLEGAL <= ~legal;
				CYCLES <= legal ? cycles : 4'h0;
			end
			if (REG_RD) begin
				REG_RDATA <= (REG_ADDR == `ALCCE_FLAGS_ADDR) ? flags_reg :
					((REG_ADDR == `ALCCE_STKP_ADDR) ? stkp_reg : 8'h00);
			end
		end
	end

	// busy while any instruction is in flight
	always @* begin
		BUSY = (state_reg != S_IDLE);
	end
endmodule // alcce_exec

// ### alcce_rfmodel.sv
// Purpose: register file and stack memory facing the execution block
// Assumes: reads answer in the same cycle, writes land on the edge
// Notes: contents start unknown, so stray reads show up
`timescale 1ns/10ps
module alcce_rfmodel (
	input wire mclk,
	input wire [7:0] rf_addr,
	output wire [7:0] rf_rdata,
	input wire [7:0] rf_waddr,
	input wire [7:0] rf_wdata,
	input wire rf_we
);
	reg [7:0] mem [0:255];
	// same-cycle read, also used for indirect pointers
	assign rf_rdata = mem[rf_addr];
	// one byte per strobe, stack pushes included
	always @(posedge mclk) begin
		if (rf_we)
			mem[rf_waddr] <= rf_wdata;
	end
endmodule // alcce_rfmodel

// ### alcce_exec_properties.sv
// Purpose: timing and port relations of the execution block
// Assumes: one clock, asynchronous low reset
// Notes: opcodes given as plain numbers
`timescale 1ns/10ps
module alcce_props (
	input wire MCLK,
	input wire RST_N,
	input wire START,
	input wire BUSY,
	input wire DONE,
	input wire PC_LOAD,
	input wire ILLEGAL,
	input wire RF_WE,
	input wire REG_RD,
	input wire [7:0] OPCODE,
	input wire [7:0] BYTE1,
	input wire [7:0] RF_WADDR,
	input wire [7:0] REG_ADDR,
	input wire [7:0] REG_RDATA,
	input wire [3:0] CYCLES
);
	default clocking cb @(posedge MCLK);
	endclocking
	default disable iff (!RST_N);
	// a start only counts while idle
	wire go = START && !BUSY;
	property p_add_time; go && OPCODE == 8'h02 |-> ##[3:4] DONE; endproperty
	a_add_time: assert property (p_add_time) else $error("add late");
	property p_call_cyc; go && OPCODE == 8'hf6 |=> CYCLES == 4'he; endproperty
	a_call_cyc: assert property (p_call_cyc) else $error("call cycles");
	property p_and_cyc; go && OPCODE == 8'h54 |=> CYCLES == 4'h6; endproperty
	a_and_cyc: assert property (p_and_cyc) else $error("and cycles");
	property p_load; PC_LOAD |-> DONE; endproperty
	a_load: assert property (p_load) else $error("load without done");
	property p_push; go && OPCODE == 8'hf6 |=> RF_WE ##1 (RF_WE && RF_WADDR == $past(RF_WADDR) - 8'h01); endproperty
	a_push: assert property (p_push) else $error("push order");
	property p_dst; go && OPCODE == 8'h02 |=> ##1 (RF_WE && RF_WADDR == {4'h0, $past(BYTE1[7:4], 2)}); endproperty
	a_dst: assert property (p_dst) else $error("add wrote wrong place");
	property p_ccf; go && OPCODE == 8'hef |=> !RF_WE [*3]; endproperty
	a_ccf: assert property (p_ccf) else $error("toggle wrote memory");
	property p_unmap; REG_RD && REG_ADDR != 8'hd5 && REG_ADDR != 8'hd9 |=> REG_RDATA == 8'h00; endproperty
	a_unmap: assert property (p_unmap) else $error("unmapped read");
	property p_illegal; go && OPCODE == 8'h00 |=> ILLEGAL && CYCLES == 4'h0; endproperty
	a_illegal: assert property (p_illegal) else $error("illegal missed");
endmodule // alcce_props
bind alcce_exec alcce_props i_props (.MCLK(MCLK), .RST_N(RST_N), .START(START), .BUSY(BUSY), .DONE(DONE),
	.PC_LOAD(PC_LOAD), .ILLEGAL(ILLEGAL), .RF_WE(RF_WE), .REG_RD(REG_RD), .OPCODE(OPCODE), .BYTE1(BYTE1),
	.RF_WADDR(RF_WADDR), .REG_ADDR(REG_ADDR), .REG_RDATA(REG_RDATA), .CYCLES(CYCLES));

// ### alcce_tb.sv
// Purpose: self-checking bench for the execution block
// Assumes: flags at d5 and stack pointer at d9 on the register port
// Notes: memory is poked directly to keep scenarios short
`timescale 1ns/10ps
module tb;
	reg mclk = 1'b0;
	reg rst_n = 1'b0;
	reg start = 1'b0;
	reg [7:0] opcode = 8'h00;
	reg [7:0] byte1 = 8'h00;
	reg [7:0] byte2 = 8'h00;
	reg [15:0] pc_in = 16'h0000;
	reg [7:0] reg_addr = 8'h00;
	reg [7:0] reg_wdata = 8'h00;
	reg reg_wr = 1'b0;
	reg reg_rd = 1'b0;
	wire [15:0] pc_out;
	wire pc_load, busy, done, illegal, rf_we;
	wire [3:0] cycles;
	wire [7:0] rf_addr, rf_rdata, rf_waddr, rf_wdata, reg_rdata;
	integer error_cnt = 0;
	integer compares = 0;
	integer i, k, n;
	reg loaded;
	reg [7:0] s, r;
	initial forever #25 mclk = ~mclk;
	alcce_exec i_dut (.MCLK(mclk), .RST_N(rst_n), .START(start), .OPCODE(opcode), .BYTE1(byte1), .BYTE2(byte2),
		.PC_IN(pc_in), .PC_OUT(pc_out), .PC_LOAD(pc_load), .BUSY(busy), .DONE(done), .ILLEGAL(illegal),
		.CYCLES(cycles), .RF_ADDR(rf_addr), .RF_RDATA(rf_rdata), .RF_WADDR(rf_waddr), .RF_WDATA(rf_wdata),
		.RF_WE(rf_we), .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata), .REG_WR(reg_wr), .REG_RD(reg_rd),
		.REG_RDATA(reg_rdata));
	alcce_rfmodel i_rf (.mclk(mclk), .rf_addr(rf_addr), .rf_rdata(rf_rdata), .rf_waddr(rf_waddr),
		.rf_wdata(rf_wdata), .rf_we(rf_we));
	task close_out;
		$display("compares %0d errors %0d", compares, error_cnt);
		if (error_cnt == 0 && compares > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task chk(input string nm, input [15:0] seen, input [15:0] exp);
		compares = compares + 1;
		if (seen !== exp) begin
			$display("ERROR %s expected %h seen %h", nm, exp, seen);
			error_cnt = error_cnt + 1;
		end
	endtask
	task wr(input [7:0] a, input [7:0] v);
		@(posedge mclk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= v;
		@(posedge mclk);
		reg_wr <= 1'b0;
	endtask
	// read data appears in the cycle after the strobe and holds until the next strobe
	task rd(input string nm, input [7:0] a, input [7:0] e);
		@(posedge mclk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge mclk);
		reg_rd <= 1'b0;
		#1 chk(nm, reg_rdata, e);
	endtask
	// bounded wait so a missing done ends the run
	task run(input [7:0] op, input [7:0] b1, input [7:0] b2, input [15:0] pc);
		@(posedge mclk);
		start <= 1'b1;
		opcode <= op;
		byte1 <= b1;
		byte2 <= b2;
		pc_in <= pc;
		@(posedge mclk);
		start <= 1'b0;
		#1 n = 0;
		while (done !== 1'b1 && n < 40) begin
			@(posedge mclk);
			#1 n = n + 1;
		end
		loaded = pc_load;
		if (n == 40) begin
			error_cnt = error_cnt + 1;
			close_out;
		end
	endtask
	task s_modes;
		for (k = 0; k < 3; k = k + 1) begin
			for (i = 0; i < 5; i = i + 1) begin
				i_rf.mem[1] = 8'h21;
				i_rf.mem[2] = 8'h03;
				i_rf.mem[3] = 8'h0a;
				wr(8'hd5, 8'h80);
				s = (i == 4) ? 8'h25 : (i[0] ? 8'h0a : 8'h03);
				r = (k == 2) ? (8'h21 & s) : 8'h21 + s + (k == 1);
				run((k == 2 ? 8'h50 : k * 16) + i + 2, i < 2 ? 8'h12 : (i == 4 ? 8'h01 : 8'h02),
					i == 4 ? 8'h25 : 8'h01, 16'h0100);
				chk("dst", i_rf.mem[1], r);
				chk("src", i_rf.mem[2], 8'h03);
				chk("cycles", cycles, i == 0 ? 4'h4 : 4'h6);
				chk("pc", pc_out, i < 2 ? 16'h0102 : 16'h0103);
				chk("time", n + 1, i == 0 ? 4 : 6);
			end
		end
	endtask
	task fcase(input [7:0] op, input [7:0] fin, input [7:0] dv, input [7:0] sv, input [7:0] res, input [7:0] fo);
		i_rf.mem[1] = dv;
		i_rf.mem[2] = sv;
		wr(8'hd5, fin);
		run(op, 8'h12, 8'h00, 16'h0000);
		chk("result", i_rf.mem[1], res);
		rd("flags", 8'hd5, fo);
	endtask
	task s_flags;
		fcase(8'h02, 8'h00, 8'h7f, 8'h01, 8'h80, 8'h30);
		fcase(8'h02, 8'h00, 8'hff, 8'h01, 8'h00, 8'hc0);
		fcase(8'h12, 8'h80, 8'hff, 8'h00, 8'h00, 8'hc0);
		fcase(8'h02, 8'h80, 8'h80, 8'h80, 8'h00, 8'hd0);
		fcase(8'h52, 8'h90, 8'hf0, 8'h8f, 8'h80, 8'ha0);
		fcase(8'h52, 8'h30, 8'h0f, 8'hf0, 8'h00, 8'h40);
	endtask
	task s_call;
		wr(8'hd9, 8'hb2);
		wr(8'hd5, 8'hf0);
		run(8'hf6, 8'h15, 8'h21, 16'h1a44);
		chk("target", pc_out, 16'h1521);
		chk("load", loaded, 1'b1);
		chk("time", n + 1, 14);
		chk("low", i_rf.mem[8'hb1], 8'h47);
		chk("high", i_rf.mem[8'hb0], 8'h1a);
		rd("sp", 8'hd9, 8'hb0);
		rd("flags", 8'hd5, 8'hf0);
		i_rf.mem[4] = 8'h15;
		i_rf.mem[5] = 8'h21;
		run(8'hf4, 8'h04, 8'h00, 16'h1a47);
		chk("target", pc_out, 16'h1521);
		chk("cycles", cycles, 4'hc);
		chk("time", n + 1, 12);
		chk("low", i_rf.mem[8'haf], 8'h49);
		run(8'haf, 8'h00, 8'h00, 16'h1521);
		chk("ret", pc_out, 16'h1a49);
		chk("load", loaded, 1'b1);
		run(8'haf, 8'h00, 8'h00, 16'h1a49);
		chk("ret", pc_out, 16'h1a47);
		rd("sp", 8'hd9, 8'hb2);
	endtask
	task s_misc;
		wr(8'hd5, 8'h00);
		run(8'hef, 8'h00, 8'h00, 16'h0200);
		rd("flags", 8'hd5, 8'h80);
		chk("cycles", cycles, 4'h4);
		chk("pc", pc_out, 16'h0201);
		chk("time", n + 1, 4);
		chk("load", loaded, 1'b0);
		wr(8'hd5, 8'hf0);
		run(8'hef, 8'h00, 8'h00, 16'h0200);
		rd("flags", 8'hd5, 8'h70);
		rd("unmapped", 8'h40, 8'h00);
		@(posedge mclk);
		start <= 1'b1;
		opcode <= 8'h00;
		@(posedge mclk);
		start <= 1'b0;
		#1 chk("illegal", illegal, 1'b1);
		chk("busy", busy, 1'b1);
	endtask
	initial begin
		repeat (16) @(posedge mclk);
		rst_n <= 1'b1;
		rd("flags", 8'hd5, 8'h00);
		s_modes;
		s_flags;
		s_call;
		s_misc;
		close_out;
	end
endmodule // tb
